/* scss_pkg.sv */
// package for the system clock select switch: register map, fields, timing
// assumes a single 200 MHz register clock and AXI4-Lite software access
package scss_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STAT_OFS   = 4'h4;
  localparam logic [3:0] SETUP_OFS  = 4'h8;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FREQ_LSB   = 3;
  localparam int FREQ_MSB   = 6;
  localparam int SRC_LSB    = 0;
  localparam int SRC_MSB    = 1;
  localparam int HRDY_BIT   = 4;
  localparam int LRDY_BIT   = 1;
  localparam int HSTB_BIT   = 0;
  localparam int DEFSRC_LSB = 0;
  localparam int DEFSRC_MSB = 1;
  localparam int CLKOE_BIT  = 11;
  localparam int SETUP_W    = 14;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0]  FREQ_RST  = 4'h7;
  localparam logic [1:0]  SRC_RST   = 2'h0;
  localparam logic [13:0] SETUP_RST = 14'h0000;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] DEF_INT = 2'h0;
  localparam logic [1:0] DEF_ECL = 2'h1;
  localparam logic [1:0] DEF_ECM = 2'h2;
  localparam logic [1:0] DEF_ECH = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int HF_START_NS  = 2000;
  localparam int HF_START_CYC = (HF_START_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC     = 2;
  localparam int SETTLE_CYC   = 8;

  // system clock source seen by the core
  typedef enum logic [2:0] {
    SCSS_SRC_EXT_LO, SCSS_SRC_EXT_MID, SCSS_SRC_EXT_HI,
    SCSS_SRC_HF, SCSS_SRC_LF
  } scss_src_e;

  typedef enum logic [1:0] {
    SCSS_IDLE, SCSS_START, SCSS_EDGE
  } scss_st_e;

endpackage

/* scss_top.sv */
// system clock select switch: control, status, setup word, switch sequencer
// assumes oscillators are modelled as ready levels and the old clock's
// falling edge is signalled as a pulse synchronous to aclk
//
// Contract
// - a stopped target oscillator is started and its delay run before takeover, except the first start after reset or a wake.
// - once new clock is ready, wait for old clock falling edge, then hand over.
// - changes within the same oscillator skip any start-up delay.
// - status always shows both oscillators' running state, even mid-switch.
// - source field 00 uses setup word source, 1x internal, 01 reserved.
// - every reset clears the source field.
// - settle waits: 2 cycles after wake, 2 us to high, 1 each to low.
// - frequency field bits 6..3, codes 1111..1011 give 16 down to 1 MHz.
// - codes 1010..1000 give 500, 250, 125 kHz from high oscillator.
// - 0111..0100 give 500..62.5 kHz, 001x 31.25 kHz, 000x low oscillator.
// - after reset the frequency field holds 0111.
// - status bit 4 reads 1 while the high oscillator is ready.
// - unimplemented bits of both registers read as zero.
// - setup source 11 high, 10 medium, 01 low power external, 00 internal.
// - stable flag only once high oscillator is within half a percent.
module scss_top #(
  parameter int HF_START = scss_pkg::HF_START_CYC, // start-up cycles
  parameter int SETTLE   = scss_pkg::SETTLE_CYC    // stable lag after ready
) (
  input  wire logic        aclk,          // 200 MHz clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic        wake,          // pulse: exit from sleep
  input  wire logic        old_clk_fall,  // pulse: falling edge of old clock
  input  wire logic        lf_clk_edge,   // pulse: edge of low oscillator
  input  wire logic [3:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [3:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  output logic [2:0]       sys_src,       // active source, scss_src_e code
  output logic [3:0]       sys_freq,      // active frequency code
  output logic             switching,     // handover pending
  output logic             hf_run,        // high oscillator ready
  output logic             lf_run,        // low oscillator ready
  output logic             clkout_en      // clock output pin enable
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic                aw_got;
    logic [3:0]          awaddr;
    logic                w_got;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [3:0]          freq;
    logic [1:0]          src;
    logic [13:0]         setup;
    scss_pkg::scss_st_e  st;
    logic [15:0]         cnt;
    logic                lf_seen;
    logic                hf_rdy;
    logic                lf_rdy;
    logic [15:0]         hf_age;
    logic [2:0]          cur_src;
    logic [3:0]          cur_freq;
    logic [2:0]          tgt_src;
    logic [3:0]          tgt_freq;
    logic                woke;
  } scss_state_s;

  scss_state_s s_q;
  scss_state_s s_d;

  // ----------------------------------------
  // decode of requested source
  // ----------------------------------------
  function automatic logic [2:0] want_src(input logic [1:0] src,
                                          input logic [3:0] freq,
                                          input logic [1:0] def);
    logic int_sel;
    int_sel = src[1] || (src == scss_pkg::SRC_RST &&
                         def == scss_pkg::DEF_INT);
    if (int_sel) begin
      if (freq[3:1] == 3'h0) begin
        want_src = 3'(scss_pkg::SCSS_SRC_LF);
      end else begin
        want_src = 3'(scss_pkg::SCSS_SRC_HF);
      end
    end else begin
      unique case (def)
        scss_pkg::DEF_ECH: want_src = 3'(scss_pkg::SCSS_SRC_EXT_HI);
        scss_pkg::DEF_ECM: want_src = 3'(scss_pkg::SCSS_SRC_EXT_MID);
        default:           want_src = 3'(scss_pkg::SCSS_SRC_EXT_LO);
      endcase
    end
  endfunction

  logic [2:0] req_src;
  logic       hf_need;
  logic       lf_need;

  always_comb begin
    logic [3:0] wa;
    logic [31:0] nw;
    logic [1:0] def;
    logic       wr_go;
    wa    = 4'h0;
    nw    = 32'h0;
    wr_go = 1'b0;
    s_d   = s_q;
    def   = s_q.setup[scss_pkg::DEFSRC_MSB:scss_pkg::DEFSRC_LSB];
    req_src = want_src(s_q.src, s_q.freq, def);
    // a pending target keeps running, else its start could never end
    hf_need = (req_src == 3'(scss_pkg::SCSS_SRC_HF)) ||
              (s_q.cur_src == 3'(scss_pkg::SCSS_SRC_HF)) ||
              (s_q.st != scss_pkg::SCSS_IDLE &&
               s_q.tgt_src == 3'(scss_pkg::SCSS_SRC_HF));
    lf_need = (req_src == 3'(scss_pkg::SCSS_SRC_LF)) ||
              (s_q.cur_src == 3'(scss_pkg::SCSS_SRC_LF)) ||
              (s_q.st != scss_pkg::SCSS_IDLE &&
               s_q.tgt_src == 3'(scss_pkg::SCSS_SRC_LF));

    // ----------------------------------------
    // AXI4-Lite write: address and data in either order
    // ----------------------------------------
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    if (wr_go) begin
      wa = {s_q.awaddr[3:2], 2'h0};
      nw = s_q.wdata;
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = scss_pkg::RESP_OKAY;
      if (wa == scss_pkg::CTRL_OFS) begin
        if (s_q.wstrb[0]) begin
          s_d.freq = nw[scss_pkg::FREQ_MSB:scss_pkg::FREQ_LSB];
          s_d.src  = nw[scss_pkg::SRC_MSB:scss_pkg::SRC_LSB];
        end
      end else if (wa == scss_pkg::SETUP_OFS) begin
        if (s_q.wstrb[0]) s_d.setup[7:0] = nw[7:0];
        if (s_q.wstrb[1]) s_d.setup[13:8] = nw[13:8];
      end else if (wa != scss_pkg::STAT_OFS) begin // status dropped
        s_d.bresp = scss_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = scss_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0;
      unique case ({s_axi_araddr[3:2], 2'h0})
        scss_pkg::CTRL_OFS: begin
          s_d.rdata[scss_pkg::FREQ_MSB:scss_pkg::FREQ_LSB] = s_q.freq;
          s_d.rdata[scss_pkg::SRC_MSB:scss_pkg::SRC_LSB]   = s_q.src;
        end
        scss_pkg::STAT_OFS: begin
          s_d.rdata[scss_pkg::HRDY_BIT] = s_q.hf_rdy;
          s_d.rdata[scss_pkg::LRDY_BIT] = s_q.lf_rdy;
          s_d.rdata[scss_pkg::HSTB_BIT] =
            s_q.hf_rdy && (s_q.hf_age >= 16'(SETTLE));
        end
        scss_pkg::SETUP_OFS: s_d.rdata[13:0] = s_q.setup;
        default: s_d.rresp = scss_pkg::RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // ----------------------------------------
    // oscillator model: ready after start-up, stops when unused
    // ----------------------------------------
    if (!hf_need) begin
      s_d.hf_rdy = 1'b0;
      s_d.hf_age = 16'h0;
    end else if (!s_q.hf_rdy) begin
      s_d.hf_age = s_q.hf_age + 16'h1;
      if (s_q.hf_age + 16'h1 >= 16'(HF_START)) begin
        s_d.hf_rdy = 1'b1;
        s_d.hf_age = 16'h0;
      end
    end else if (s_q.hf_age < 16'(SETTLE)) begin
      s_d.hf_age = s_q.hf_age + 16'h1;
    end
    if (!lf_need) begin
      s_d.lf_rdy = 1'b0;
    end else if (lf_clk_edge) begin
      s_d.lf_rdy = 1'b1;
    end
    // ----------------------------------------
    // switch sequencer
    // ----------------------------------------
    unique case (s_q.st)
      scss_pkg::SCSS_IDLE: begin
        if (req_src != s_q.cur_src || s_q.freq != s_q.cur_freq) begin
          s_d.tgt_src  = req_src;
          s_d.tgt_freq = s_q.freq;
          s_d.cnt      = 16'h0;
          s_d.lf_seen  = 1'b0;
          if (req_src == s_q.cur_src) begin
            s_d.st = scss_pkg::SCSS_EDGE;
          end else begin
            s_d.st = scss_pkg::SCSS_START;
          end
        end
      end
      scss_pkg::SCSS_START: begin
        if (lf_clk_edge) s_d.lf_seen = 1'b1;
        if (s_q.woke) begin
          s_d.cnt = s_q.cnt + 16'h1;
          if (s_q.cnt + 16'h1 >= 16'(scss_pkg::WAKE_CYC)) begin
            s_d.st   = scss_pkg::SCSS_EDGE;
            s_d.woke = 1'b0;
          end
        end else if (s_q.tgt_src == 3'(scss_pkg::SCSS_SRC_HF)) begin
          if (s_q.hf_rdy) s_d.st = scss_pkg::SCSS_EDGE;
        end else if (s_q.tgt_src == 3'(scss_pkg::SCSS_SRC_LF)) begin
          if (s_q.lf_rdy && s_q.lf_seen && old_clk_fall) begin
            s_d.st = scss_pkg::SCSS_EDGE;
          end
        end else begin
          s_d.st = scss_pkg::SCSS_EDGE;
        end
      end
      scss_pkg::SCSS_EDGE: begin
        if (old_clk_fall) begin
          s_d.cur_src  = s_q.tgt_src;
          s_d.cur_freq = s_q.tgt_freq;
          s_d.st       = scss_pkg::SCSS_IDLE;
        end
      end
    endcase
    // after the sequencer so a wake in the clearing cycle still wins
    if (wake) s_d.woke = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.freq     <= scss_pkg::FREQ_RST;
      s_q.src      <= scss_pkg::SRC_RST;
      s_q.setup    <= scss_pkg::SETUP_RST;
      s_q.st       <= scss_pkg::SCSS_IDLE;
      s_q.cur_src  <= 3'(scss_pkg::SCSS_SRC_EXT_LO);
      s_q.cur_freq <= scss_pkg::FREQ_RST;
      s_q.woke     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs, all straight from state
  // ----------------------------------------
  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready  = !s_q.w_got;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign sys_src       = s_q.cur_src;
  assign sys_freq      = s_q.cur_freq;
  assign switching     = s_q.st != scss_pkg::SCSS_IDLE;
  assign hf_run        = s_q.hf_rdy;
  assign lf_run        = s_q.lf_rdy;
  assign clkout_en     = s_q.setup[scss_pkg::CLKOE_BIT];

endmodule

/* scss_monitor.sv */
// checker for scss_top: port relations of the switch and register slave
// assumes it is bound to scss_top, one clock, synchronous active-low reset
module scss_monitor #(
  parameter int HF_START = scss_pkg::HF_START_CYC // start-up cycles
) (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, active low
  input wire logic        old_clk_fall,  // old clock fall
  input wire logic [3:0]  s_axi_araddr,  // read address
  input wire logic        s_axi_arvalid, // read address valid
  input wire logic        s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic [1:0]  s_axi_rresp,   // read response
  input wire logic        s_axi_rvalid,  // read data valid
  input wire logic [2:0]  sys_src,       // active source
  input wire logic [3:0]  sys_freq,      // active frequency
  input wire logic        switching,     // handover pending
  input wire logic        hf_run,        // high oscillator ready
  input wire logic        lf_run         // low oscillator ready
);
  // ----
  // helpers
  // ----
  logic [3:0]  rd_addr_q;
  int unsigned hf_off_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
    hf_off_q <= (!aresetn || hf_run) ? 0 : hf_off_q + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_vals;
    $rose(aresetn) |-> sys_freq == 4'h7 && sys_src == 3'h0 && !switching;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values");
  property p_freq_on_fall;
    $changed(sys_freq) && $past(aresetn) |-> $past(old_clk_fall);
  endproperty
  a_freq_on_fall: assert property (p_freq_on_fall)
    else $error("no fall");
  // the count may exceed the delay when start is requested late
  property p_hf_start;
    $rose(hf_run) |-> hf_off_q >= HF_START - 1;
  endproperty
  a_hf_start: assert property (p_hf_start)
    else $error("short start");
  property p_stat_read;
    $rose(s_axi_rvalid) && rd_addr_q == scss_pkg::STAT_OFS |->
      s_axi_rdata[4] == $past(hf_run) && s_axi_rdata[1] == $past(lf_run);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status bits");
  property p_stat_zero;
    s_axi_rvalid && rd_addr_q == scss_pkg::STAT_OFS |->
      (s_axi_rdata & 32'hFFFFFFEC) == 32'h0 &&
      (!s_axi_rdata[0] || s_axi_rdata[4]);
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("status zero");
  property p_ctrl_zero;
    s_axi_rvalid && rd_addr_q == scss_pkg::CTRL_OFS |->
      (s_axi_rdata & 32'hFFFFFF84) == 32'h0;
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero)
    else $error("control zero");
  property p_switch_bound;
    $rose(switching) |-> ##[1:1000] !switching;
  endproperty
  a_switch_bound: assert property (p_switch_bound)
    else $error("stuck");
  property p_unmapped;
    $rose(s_axi_rvalid) && rd_addr_q[3:2] == 2'h3 |->
      s_axi_rresp == scss_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read");
  c_hf_start: cover property ($rose(hf_run));
  c_freq_chg: cover property ($changed(sys_freq));
  c_lf_start: cover property ($rose(lf_run));
endmodule

bind scss_top scss_monitor #(.HF_START(HF_START)) scss_monitor_i (
  .aclk, .aresetn, .old_clk_fall, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .sys_src,
  .sys_freq, .switching, .hf_run, .lf_run
);

/* testbench.sv */
// self-checking bench for scss_top: registers and switch sequencing
// assumes scss_monitor is compiled alongside and binds itself
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HFS = 60; // shortened start-up
  logic        aclk, aresetn, wake, old_clk_fall, lf_clk_edge;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  sys_src;
  logic [3:0]  sys_freq;
  logic        switching, hf_run, lf_run, clkout_en;
  int          errors = 0, checks_done = 0, cyc = 0;
  scss_top #(.HF_START(HFS), .SETTLE(2)) scss_top_i (
    .aclk, .aresetn, .wake, .old_clk_fall, .lf_clk_edge, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_src,
    .sys_freq, .switching, .hf_run, .lf_run, .clkout_en
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // random edge pulses keep every handover moving; timeout cuts hangs
  always @(posedge aclk) begin
    old_clk_fall <= ($urandom % 2) == 0;
    lf_clk_edge  <= ($urandom % 3) == 0;
    cyc          <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic settle(output int n);
    n = 0;
    repeat (2) @(posedge aclk);
    while (switching === 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      tally_and_finish();
    end
  endtask
  function automatic logic [2:0] exp_src(logic [1:0] scs, def,
                                         logic [3:0] f);
    if (scs[1] || def == scss_pkg::DEF_INT)
      return f[3:1] == 3'h0 ? scss_pkg::SCSS_SRC_LF : scss_pkg::SCSS_SRC_HF;
    return {1'b0, def - 2'h1};
  endfunction
  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] d, e;
    logic [1:0]  r;
    logic [3:0]  f;
    logic [2:0]  es, ps;
    int          n;
    void'($urandom(32'h7813));
    aresetn = 1'b0;
    wake = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(scss_pkg::CTRL_OFS, d, r);
    chk(d, 32'h38);
    for (int i = 0; i < 4; i++) begin
      d = ($urandom & 32'h3FFC) | i;
      wr(scss_pkg::SETUP_OFS, d, r);
      settle(n);
      chk(sys_src, exp_src(2'h0, d[1:0], 4'h7));
      chk(clkout_en, d[11]);
      rd(scss_pkg::SETUP_OFS, e, r);
      chk(e, d & 32'h3FFF);
    end
    ps = exp_src(2'h0, 2'h3, 4'h7);
    for (int i = 15; i >= -1; i--) begin
      f = i < 0 ? 4'hF : i[3:0];
      d = ($urandom & 32'hFFFFFF85) | {f, 3'h2};
      es = exp_src(2'h2, 2'h0, f);
      wr(scss_pkg::CTRL_OFS, d, r);
      settle(n);
      chk(sys_freq, f);
      chk(sys_src, es);
      chk(n >= HFS - 3, es == 3'h3 && ps != 3'h3);
      ps = es;
      rd(scss_pkg::CTRL_OFS, e, r);
      chk(e, d & 32'h7B);
      wr(scss_pkg::STAT_OFS, $urandom, r);
      chk(r, scss_pkg::RESP_OKAY);
      rd(scss_pkg::STAT_OFS, e, r);
      chk(e, es == 3'h3 ? 32'h11 : 32'h02);
      chk({hf_run, lf_run}, es == 3'h3 ? 2'h2 : 2'h1);
    end
    // a wake pulse swaps the next start-up for the short fixed wait
    wr(scss_pkg::CTRL_OFS, 32'h2, r);
    settle(n);
    chk(sys_src, exp_src(2'h2, 2'h0, 4'h0));
    @(posedge aclk);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    wr(scss_pkg::CTRL_OFS, 32'h7A, r);
    settle(n);
    chk(n < HFS - 3, 1'b1);
    chk(sys_src, exp_src(2'h2, 2'h0, 4'hF));
    chk(sys_freq, 4'hF);
    wr(4'hC, $urandom, r);
    chk(r, scss_pkg::RESP_SLVERR);
    rd(4'hC, e, r);
    chk(e, 32'h0);
    chk(r, scss_pkg::RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(scss_pkg::CTRL_OFS, d, r);
    chk(d, 32'h38);
    chk(sys_freq, 4'h7);
    tally_and_finish();
  end
endmodule
